//--- src/cmeh_defs.svh
// constants for the correctable memory error handler
`ifndef CMEH_DEFS_SVH
`define CMEH_DEFS_SVH
`define CMEH_CNT_W      16
`define CMEH_ADDR_W     16
`define CMEH_DATA_W     32
`define CMEH_SET_W      8
`define CMEH_CNT_ZERO   16'h0000
`define CMEH_CNT_MAX    16'hFFFF
`define CMEH_CNT_ONE    16'h0001
`endif

//--- src/cmeh_pkg.sv
// types for the correctable memory error handler
package cmeh_pkg;
    typedef enum logic [2:0]
    {
        CMEH_IDLE  = 3'b001,
        CMEH_FLUSH = 3'b010,
        CMEH_WBACK = 3'b100
    } cmeh_ilm_state_t;
endpackage : cmeh_pkg

//--- src/cmeh_cnt_if.sv
// count request and threshold result between handler and counter
`include "cmeh_defs.svh"
interface cmeh_cnt_if;
    logic                   inc;
    logic [`CMEH_CNT_W-1:0] threshold;
    logic [`CMEH_CNT_W-1:0] count;
    logic                   hit;
    modport ctl (output inc, output threshold, input count, input hit);
    modport cnt (input inc, input threshold, output count, output hit);
endinterface : cmeh_cnt_if

//--- src/cmeh_counter.sv
// saturating error counter with threshold compare
`include "cmeh_defs.svh"
module cmeh_counter
(
    input  wire logic clk,
    input  wire logic rstn,
    cmeh_cnt_if.cnt   c
);
    logic [`CMEH_CNT_W-1:0] count_r;
    logic                   hit_r;
    logic [`CMEH_CNT_W-1:0] count_nxt;

    // count only; no location kept
    always_comb
    begin
        count_nxt = count_r;
        if (c.inc && count_r != `CMEH_CNT_MAX)
        begin
            count_nxt = count_r + `CMEH_CNT_ONE;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            count_r <= `CMEH_CNT_ZERO;
        end
        else
        begin
            count_r <= count_nxt;
        end
    end

    // pulse the cycle the threshold is first reached
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            hit_r <= 1'b0;
        end
        else
        begin
            hit_r <= c.inc && (c.threshold != `CMEH_CNT_ZERO) && (count_nxt == c.threshold)
                && (count_r != c.threshold);
        end
    end

    assign c.count = count_r;
    assign c.hit   = hit_r;
endmodule : cmeh_counter

//--- src/cmeh_handler.sv
// correctable error handler for icache, instruction and data local memories
`include "cmeh_defs.svh"
module cmeh_handler
(
    input  wire logic                    clk,
    input  wire logic                    rstn,
    input  wire logic [`CMEH_CNT_W-1:0]  ic_threshold,
    input  wire logic [`CMEH_CNT_W-1:0]  ilm_threshold,
    input  wire logic [`CMEH_CNT_W-1:0]  dlm_threshold,
    input  wire logic                    ic_fetch_err,
    input  wire logic [`CMEH_SET_W-1:0]  ic_fetch_set,
    input  wire logic                    ilm_fetch_err,
    input  wire logic [`CMEH_ADDR_W-1:0] ilm_fetch_addr,
    input  wire logic [`CMEH_DATA_W-1:0] ilm_fetch_fixed,
    input  wire logic                    dlm_ls_err,
    input  wire logic                    dlm_ls_spec,
    input  wire logic                    dlm_ls_side_effect,
    input  wire logic [`CMEH_ADDR_W-1:0] dlm_ls_addr,
    input  wire logic [`CMEH_DATA_W-1:0] dlm_ls_fixed,
    input  wire logic                    dma_rd_ilm_err,
    input  wire logic                    dma_rd_dlm_err,
    input  wire logic [`CMEH_ADDR_W-1:0] dma_rd_addr,
    input  wire logic [`CMEH_DATA_W-1:0] dma_rd_fixed,
    input  wire logic                    dma_wr,
    output logic                         refetch_pc_flush,
    output logic                         ic_inval,
    output logic [`CMEH_SET_W-1:0]       ic_inval_set,
    output logic                         ilm_wr,
    output logic [`CMEH_ADDR_W-1:0]      ilm_wr_addr,
    output logic [`CMEH_DATA_W-1:0]      ilm_wr_data,
    output logic                         dlm_wr,
    output logic [`CMEH_ADDR_W-1:0]      dlm_wr_addr,
    output logic [`CMEH_DATA_W-1:0]      dlm_wr_data,
    output logic                         ilm_refetch,
    output logic                         corr_err_irq,
    output logic [`CMEH_CNT_W-1:0]       ic_count,
    output logic [`CMEH_CNT_W-1:0]       ilm_count,
    output logic [`CMEH_CNT_W-1:0]       dlm_count
);
    // ------------------------------------------------------------
    // counters
    // ------------------------------------------------------------
    // slot 0 icache, slot 1 instruction memory, slot 2 data memory
    cmeh_cnt_if cnt_c [3] ();

    generate
        for (genvar g = 0; g < 3; g++)
        begin : g_cnt
            cmeh_counter u_cnt (.clk(clk), .rstn(rstn), .c(cnt_c[g]));
        end
    endgenerate

    logic                      dlm_ls_ok;
    logic                      ilm_take;
    cmeh_pkg::cmeh_ilm_state_t state_r;
    cmeh_pkg::cmeh_ilm_state_t state_nxt;

    // side effect attribute deliberately not consulted
    assign dlm_ls_ok = dlm_ls_err && !dlm_ls_spec;

    // ignore new fetch errors while a flush is in flight
    assign ilm_take = ilm_fetch_err && (state_r == cmeh_pkg::CMEH_IDLE);

    assign cnt_c[0].inc       = ic_fetch_err;
    assign cnt_c[0].threshold = ic_threshold;
    assign cnt_c[1].inc       = ilm_take || dma_rd_ilm_err;
    assign cnt_c[1].threshold = ilm_threshold;
    assign cnt_c[2].inc       = dlm_ls_ok || dma_rd_dlm_err;
    assign cnt_c[2].threshold = dlm_threshold;

    assign ic_count  = cnt_c[0].count;
    assign ilm_count = cnt_c[1].count;
    assign dlm_count = cnt_c[2].count;

    // ------------------------------------------------------------
    // interrupt
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            corr_err_irq <= 1'b0;
        end
        else
        begin
            corr_err_irq <= cnt_c[0].hit || cnt_c[1].hit || cnt_c[2].hit;
        end
    end

    // ------------------------------------------------------------
    // icache: set invalidate and flush
    // ------------------------------------------------------------
    // ecc on tag and data: any detected error, single or double, refetches
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ic_inval     <= 1'b0;
            ic_inval_set <= {`CMEH_SET_W{1'b0}};
        end
        else
        begin
            ic_inval <= ic_fetch_err;
            if (ic_fetch_err)
            begin
                ic_inval_set <= ic_fetch_set;
            end
        end
    end

    // ------------------------------------------------------------
    // instruction memory sequencer
    // ------------------------------------------------------------
    logic [`CMEH_ADDR_W-1:0]   fix_addr_r;
    logic [`CMEH_DATA_W-1:0]   fix_data_r;

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            cmeh_pkg::CMEH_IDLE:
            begin
                if (ilm_fetch_err)
                begin
                    state_nxt = cmeh_pkg::CMEH_FLUSH;
                end
            end
            cmeh_pkg::CMEH_FLUSH:
            begin
                state_nxt = cmeh_pkg::CMEH_WBACK;
            end
            cmeh_pkg::CMEH_WBACK:
            begin
                state_nxt = cmeh_pkg::CMEH_IDLE;
            end
            default:
            begin
                state_nxt = cmeh_pkg::CMEH_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_r <= cmeh_pkg::CMEH_IDLE;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            fix_addr_r <= {`CMEH_ADDR_W{1'b0}};
            fix_data_r <= {`CMEH_DATA_W{1'b0}};
        end
        else if (ilm_take)
        begin
            fix_addr_r <= ilm_fetch_addr;
            fix_data_r <= ilm_fetch_fixed;
        end
    end

    // flush covers both icache and instruction memory errors
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            refetch_pc_flush <= 1'b0;
            ilm_refetch      <= 1'b0;
        end
        else
        begin
            refetch_pc_flush <= ic_fetch_err || ilm_take;
            ilm_refetch      <= (state_r == cmeh_pkg::CMEH_WBACK);
        end
    end

    // ------------------------------------------------------------
    // write back ports
    // ------------------------------------------------------------
    // flush write back wins the port; a colliding dma read fix is dropped
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ilm_wr      <= 1'b0;
            ilm_wr_addr <= {`CMEH_ADDR_W{1'b0}};
            ilm_wr_data <= {`CMEH_DATA_W{1'b0}};
        end
        else if (state_r == cmeh_pkg::CMEH_FLUSH)
        begin
            ilm_wr      <= 1'b1;
            ilm_wr_addr <= fix_addr_r;
            ilm_wr_data <= fix_data_r;
        end
        else
        begin
            ilm_wr      <= dma_rd_ilm_err && !dma_wr;
            ilm_wr_addr <= dma_rd_addr;
            ilm_wr_data <= dma_rd_fixed;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            dlm_wr      <= 1'b0;
            dlm_wr_addr <= {`CMEH_ADDR_W{1'b0}};
            dlm_wr_data <= {`CMEH_DATA_W{1'b0}};
        end
        else if (dlm_ls_ok)
        begin
            dlm_wr      <= 1'b1;
            dlm_wr_addr <= dlm_ls_addr;
            dlm_wr_data <= dlm_ls_fixed;
        end
        else
        begin
            dlm_wr      <= dma_rd_dlm_err && !dma_wr;
            dlm_wr_addr <= dma_rd_addr;
            dlm_wr_data <= dma_rd_fixed;
        end
    end

    logic unused_side;
    assign unused_side = dlm_ls_side_effect;
endmodule : cmeh_handler

//--- bench/cmeh_chk.sv
// port assertions for the correctable memory error handler
module cmeh_chk
(
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic [15:0] ic_threshold,
    input wire logic [15:0] dlm_threshold,
    input wire logic        ic_fetch_err,
    input wire logic        dlm_ls_err,
    input wire logic        dlm_ls_spec,
    input wire logic [31:0] dlm_ls_fixed,
    input wire logic        dma_rd_ilm_err,
    input wire logic        dma_rd_dlm_err,
    input wire logic [31:0] dma_rd_fixed,
    input wire logic        dma_wr,
    input wire logic        refetch_pc_flush,
    input wire logic        ic_inval,
    input wire logic        ilm_wr,
    input wire logic        dlm_wr,
    input wire logic [31:0] dlm_wr_data,
    input wire logic        ilm_refetch,
    input wire logic        corr_err_irq,
    input wire logic [15:0] ic_count,
    input wire logic [15:0] dlm_count
);
timeunit 1ns;
timeprecision 1ps;
default clocking @(posedge clk); endclocking
default disable iff (!rstn);
a_ic_flush: assert property (ic_fetch_err |=> ic_inval && refetch_pc_flush)
    else $error("icache error without flush");
a_ic_count: assert property (ic_fetch_err && ic_count != 16'hffff
    |=> ic_count == $past(ic_count) + 16'h0001) else $error("icache count");
a_ic_irq: assert property ($changed(ic_count) && ic_count == ic_threshold
    && ic_threshold != 16'h0000 |=> corr_err_irq) else $error("icache irq missing");
a_dlm_irq: assert property ($changed(dlm_count) && dlm_count == dlm_threshold
    && dlm_threshold != 16'h0000 |=> corr_err_irq) else $error("data irq missing");
a_ilm_walk: assert property (ilm_refetch |-> $past(ilm_wr)
    && $past(refetch_pc_flush, 2)) else $error("refetch out of order");
a_dlm_fix: assert property (dlm_ls_err && !dlm_ls_spec
    |=> dlm_wr && dlm_wr_data == $past(dlm_ls_fixed)) else $error("data fix");
a_spec_drop: assert property (dlm_ls_err && dlm_ls_spec && !dma_rd_dlm_err
    |=> !dlm_wr && $stable(dlm_count)) else $error("speculative handled");
a_dma_fix: assert property (dma_rd_dlm_err && !dma_wr && !dlm_ls_err
    |=> dlm_wr && dlm_wr_data == $past(dma_rd_fixed)) else $error("dma fix");
a_dma_quiet: assert property (dma_wr && !dma_rd_dlm_err && !dma_rd_ilm_err
    && !dlm_ls_err && !refetch_pc_flush |=> !dlm_wr && !ilm_wr) else $error("dma wr");
endmodule : cmeh_chk
bind cmeh_handler cmeh_chk u_chk (.clk, .rstn, .ic_threshold, .dlm_threshold,
    .ic_fetch_err, .dlm_ls_err, .dlm_ls_spec, .dlm_ls_fixed, .dma_rd_ilm_err,
    .dma_rd_dlm_err, .dma_rd_fixed, .dma_wr, .refetch_pc_flush, .ic_inval, .ilm_wr,
    .dlm_wr, .dlm_wr_data, .ilm_refetch, .corr_err_irq, .ic_count, .dlm_count);

//--- bench/cmeh_mem_model.sv
// local memory arrays that take the handler's corrected write backs
module cmeh_mem_model
(
    input wire logic        clk,
    input wire logic        ilm_wr,
    input wire logic [15:0] ilm_wr_addr,
    input wire logic [31:0] ilm_wr_data,
    input wire logic        dlm_wr,
    input wire logic [15:0] dlm_wr_addr,
    input wire logic [31:0] dlm_wr_data,
    input wire logic        sys_err,
    input wire logic [15:0] sys_addr,
    input wire logic [31:0] sys_fixed,
    input wire logic [15:0] sys_threshold
);
timeunit 1ns;
timeprecision 1ps;
logic [31:0] ilm_mem [logic [15:0]];
logic [31:0] dlm_mem [logic [15:0]];
logic [31:0] sys_mem [logic [15:0]];
logic [15:0] sys_count = 16'h0000;
logic        sys_irq   = 1'b0;
// bus side memory: fixes at its own boundary, counts and raises its
// external interrupt by itself, so the handler never sees these errors
always @(posedge clk)
begin
    sys_irq = 1'b0;
    if (sys_err)
    begin
        sys_mem[sys_addr] = sys_fixed;
        sys_count = sys_count + 16'h0001;
        sys_irq = (sys_count == sys_threshold);
    end
end
// whole words replace the stored word, check bits included
always @(posedge clk)
begin
    if (ilm_wr)
        ilm_mem[ilm_wr_addr] = ilm_wr_data;
    if (dlm_wr)
        dlm_mem[dlm_wr_addr] = dlm_wr_data;
end
endmodule : cmeh_mem_model

//--- bench/tb_top.sv
// self-checking bench for the correctable memory error handler
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin mismatches++; \
    $display("[ERR] %s exp %0h got %0h", n, e, a); end end
module tb_top;
timeunit 1ns;
timeprecision 1ps;
logic clk, rstn, ic_fetch_err, ilm_fetch_err, dlm_ls_err, dlm_ls_spec, dlm_ls_side_effect;
logic dma_rd_ilm_err, dma_rd_dlm_err, dma_wr, refetch_pc_flush, ic_inval, ilm_wr, dlm_wr;
logic ilm_refetch, corr_err_irq;
logic [7:0]  ic_fetch_set, ic_inval_set;
logic [15:0] ic_threshold, ilm_threshold, dlm_threshold, ilm_fetch_addr, dlm_ls_addr;
logic [15:0] dma_rd_addr, ilm_wr_addr, dlm_wr_addr, ic_count, ilm_count, dlm_count;
logic [31:0] ilm_fetch_fixed, dlm_ls_fixed, dma_rd_fixed, ilm_wr_data, dlm_wr_data;
logic        sys_err;
logic [15:0] sys_addr, sys_threshold;
logic [31:0] sys_fixed;
int mismatches = 0;
int check_count = 0;
cmeh_handler dut (.clk, .rstn, .ic_threshold, .ilm_threshold, .dlm_threshold,
    .ic_fetch_err, .ic_fetch_set, .ilm_fetch_err, .ilm_fetch_addr, .ilm_fetch_fixed,
    .dlm_ls_err, .dlm_ls_spec, .dlm_ls_side_effect, .dlm_ls_addr, .dlm_ls_fixed,
    .dma_rd_ilm_err, .dma_rd_dlm_err, .dma_rd_addr, .dma_rd_fixed, .dma_wr,
    .refetch_pc_flush, .ic_inval, .ic_inval_set, .ilm_wr, .ilm_wr_addr, .ilm_wr_data,
    .dlm_wr, .dlm_wr_addr, .dlm_wr_data, .ilm_refetch, .corr_err_irq, .ic_count,
    .ilm_count, .dlm_count);
cmeh_mem_model mem (.clk, .ilm_wr, .ilm_wr_addr, .ilm_wr_data, .dlm_wr, .dlm_wr_addr,
    .dlm_wr_data, .sys_err, .sys_addr, .sys_fixed, .sys_threshold);
initial
begin
    clk = 1'b0;
    forever #5 clk = ~clk;
end
task automatic step(int n = 1);
    repeat (n) @(posedge clk);
    #1;
endtask : step
task automatic final_report;
    if (mismatches == 0 && check_count > 0)
        $display("verification passed");
    else
        $display("verification failed");
    $finish;
endtask : final_report
task automatic t_icache;
    ic_threshold = 16'h0002;
    for (int i = 0; i < 2; i++)
    begin
        ic_fetch_err = 1'b1;
        ic_fetch_set = 8'h5a + 8'(i);
        step();
        ic_fetch_err = 1'b0;
        `CHK("ic_inval", 1'b1, ic_inval)
        `CHK("ic_inval_set", 8'h5a + 8'(i), ic_inval_set)
        `CHK("flush", 1'b1, refetch_pc_flush)
        `CHK("ic_count", 16'(i + 1), ic_count)
        step();
        `CHK("ic_irq", 1'(i), corr_err_irq)
    end
endtask : t_icache
task automatic t_ilm;
    ilm_threshold = 16'h0001;
    ilm_fetch_err = 1'b1;
    ilm_fetch_addr = 16'h0040;
    ilm_fetch_fixed = 32'hcafe_0001;
    step();
    ilm_fetch_addr = 16'h0044; // lands in the busy window
    `CHK("ilm_flush", 1'b1, refetch_pc_flush)
    step();
    ilm_fetch_err = 1'b0;
    `CHK("ilm_wr", 1'b1, ilm_wr)
    `CHK("ilm_wr_addr", 16'h0040, ilm_wr_addr)
    `CHK("ilm_irq", 1'b1, corr_err_irq)
    step();
    `CHK("ilm_refetch", 1'b1, ilm_refetch)
    `CHK("ilm_mem", 32'hcafe_0001, mem.ilm_mem[16'h0040])
    `CHK("ilm_count", 16'h0001, ilm_count)
endtask : t_ilm
task automatic t_dlm;
    dlm_threshold = 16'h0002;
    for (int i = 0; i < 3; i++)
    begin
        dlm_ls_err = 1'b1;
        dlm_ls_side_effect = (i == 2);
        dlm_ls_spec = (i == 1);
        dlm_ls_addr = 16'h0010 << i;
        dlm_ls_fixed = 32'hd1a0_0000 + 32'(i);
        step();
        dlm_ls_err = 1'b0;
        `CHK("dlm_wr", 1'(i != 1), dlm_wr)
        `CHK("dlm_count", 16'(i / 2 + 1), dlm_count)
        step();
        `CHK("dlm_irq", 1'(i == 2), corr_err_irq)
    end
endtask : t_dlm
task automatic t_dma;
    for (int i = 0; i < 3; i++)
    begin
        {dma_rd_ilm_err, dma_rd_dlm_err, dma_wr} = {i == 0, i != 0, i == 2};
        dma_rd_addr = 16'h0080 + 16'(i);
        dma_rd_fixed = 32'hd0a0_0000 + 32'(i);
        step();
        {dma_rd_ilm_err, dma_rd_dlm_err, dma_wr} = 3'h0;
        `CHK("dma_ilm_wr", 1'(i == 0), ilm_wr)
        `CHK("dma_dlm_wr", 1'(i == 1), dlm_wr)
        `CHK("dma_ilm_count", 16'h0002, ilm_count)
        `CHK("dma_dlm_count", 16'(i + 2), dlm_count)
    end
    step();
    `CHK("dma_ilm_mem", 32'hd0a0_0000, mem.ilm_mem[16'h0080])
    `CHK("dma_dlm_mem", 32'hd0a0_0001, mem.dlm_mem[16'h0081])
    dma_wr = 1'b1;
    step();
    dma_wr = 1'b0;
    `CHK("dma_wr_quiet", 2'h0, {ilm_wr, dlm_wr})
endtask : t_dma
task automatic t_sys;
    sys_threshold = 16'h0002;
    for (int i = 0; i < 2; i++)
    begin
        sys_err = 1'b1;
        sys_addr = 16'h0100 + 16'(i);
        sys_fixed = 32'h5e50_0000 + 32'(i);
        step();
        sys_err = 1'b0;
        `CHK("sys_mem", 32'h5e50_0000 + 32'(i), mem.sys_mem[16'h0100 + 16'(i)])
        `CHK("sys_irq", 1'(i), mem.sys_irq)
        `CHK("sys_no_local_irq", 1'b0, corr_err_irq)
        `CHK("sys_no_local_cnt", 16'h0002, ic_count)
    end
endtask : t_sys
initial
begin
    {rstn, ic_fetch_err, ilm_fetch_err, dlm_ls_err, dlm_ls_spec, dlm_ls_side_effect} = 6'h00;
    {dma_rd_ilm_err, dma_rd_dlm_err, dma_wr, ic_fetch_set} = 11'h000;
    {ic_threshold, ilm_threshold, dlm_threshold, ilm_fetch_addr, dlm_ls_addr} = 80'h0;
    {dma_rd_addr, ilm_fetch_fixed, dlm_ls_fixed, dma_rd_fixed} = 112'h0;
    {sys_err, sys_addr, sys_threshold, sys_fixed} = 65'h0;
    step(20);
    rstn = 1'b1;
    step(2);
    t_icache();
    t_ilm();
    t_dlm();
    t_dma();
    t_sys();
    step(2);
    final_report();
end
// guards against a hang in any scenario
initial
begin
    repeat (5000) @(posedge clk);
    mismatches++;
    final_report();
end
endmodule : tb_top
